// ===== hw/tstc_core.sv
// Thermostat three-wire control: serial command port, conversion
// sequencing, config/status register and thermostat outputs.
// Assumes the analog converter presents its result words on the
// meas_* inputs, stable when a conversion period ends.
module tstc_core
    import tstc_pkg::*;
#(
    parameter int CONV_CYC = `TSTC_CONV_CYC,
    parameter int NV_CYC = `TSTC_NV_WRITE_MS * (`TSTC_CLK_HZ / 1000),
    parameter int PULSE_CYC = `TSTC_PULSE_MS * (`TSTC_CLK_HZ / 1000)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic frame_pin,
    input wire logic clk_or_convert_pin,
    input wire logic sio_in,
    output logic sio_out,
    output logic sio_oe,
    input wire logic [8:0] meas_temp,
    input wire logic [8:0] meas_remain,
    input wire logic [8:0] meas_slope,
    output logic over_limit_out,
    output logic under_limit_out,
    output logic hysteresis_out
);
    localparam int CW = `TSTC_CNT_W;
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
    localparam logic [CW-1:0] NV_LAST = CW'(NV_CYC - 1);
    localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);

    // ---------------------------------------------------------------
    // State record
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [2:0] frm_s;       // Frame synchroniser and history.
        logic [2:0] clk_s;       // Serial clock synchroniser and history.
        logic [1:0] din_s;       // Data input synchroniser.
        tstc_ser_t ser;          // Serial port state.
        logic [7:0] cmd;         // Command shift register.
        logic [3:0] bits;        // Bits taken in the current phase.
        logic [8:0] rx;          // Write data shift register.
        logic [8:0] tx;          // Read data shift register.
        tstc_tgt_t tgt;          // Target of the write in progress.
        logic [8:0] temp;        // Last conversion result.
        logic [8:0] remain;      // Count remaining of last conversion.
        logic [8:0] slope;       // Slope count of last conversion.
        logic [8:0] upper;       // Upper trip value.
        logic [8:0] lower;       // Lower trip value.
        logic upf;               // Upper seen flag.
        logic lof;               // Lower seen flag.
        logic host_sel;          // Pin is only a serial clock.
        logic single;            // Single conversion mode.
        logic conv_busy;         // Conversion in progress.
        logic [CW-1:0] conv_cnt; // Conversion period counter.
        logic one_req;           // One conversion requested.
        logic run;               // Continuous conversion enabled.
        logic pin_cont;          // Pin held low long enough.
        logic [CW-1:0] low_cnt;  // Pin low time counter.
        logic nv_busy;           // Nonvolatile write in progress.
        logic [CW-1:0] nv_cnt;   // Nonvolatile write timer.
        tstc_wr_t [1:0] fifo;    // Two-entry commit buffer.
        logic wp;                // Buffer write pointer.
        logic rp;                // Buffer read pointer.
        logic [1:0] fill;        // Buffer occupancy.
        logic hi_o;              // Over-limit output.
        logic lo_o;              // Under-limit output.
        logic com_o;             // Hysteresis output.
        logic sio_o;             // Data pin level.
        logic sio_e;             // Data pin enable.
    } tstc_core_t;

    tstc_core_t s_r;
    tstc_core_t s_nxt;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Assembles the config/status byte; fixed bits are constants.
    function automatic logic [7:0] cfg_byte(input tstc_core_t s);
        logic [7:0] c;
        c = 8'h00;
        c[`TSTC_CFG_DONE] = ~s.conv_busy;
        c[`TSTC_CFG_UPF] = s.upf;
        c[`TSTC_CFG_LOF] = s.lof;
        c[`TSTC_CFG_NVB] = s.nv_busy;
        c[`TSTC_CFG_ONE] = 1'b1;
        c[`TSTC_CFG_ZERO] = 1'b0;
        c[`TSTC_CFG_HOST] = s.host_sel;
        c[`TSTC_CFG_SINGLE] = s.single;
        return c;
    endfunction

    // Signed compare of two nine-bit temperatures.
    function automatic logic t_ge(input logic [8:0] a, input logic [8:0] b);
        return $signed(a) >= $signed(b);
    endfunction

    // Word loaded for a read command; unknown codes read zero.
    function automatic logic [8:0] rd_word(input tstc_core_t s,
                                           input logic [7:0] c);
        unique case (c)
            `TSTC_CMD_RD_TEMP: rd_word = s.temp;
            `TSTC_CMD_RD_REM: rd_word = s.remain;
            `TSTC_CMD_RD_SLOPE: rd_word = s.slope;
            `TSTC_CMD_RD_UPPER: rd_word = s.upper;
            `TSTC_CMD_RD_LOWER: rd_word = s.lower;
            `TSTC_CMD_RD_CFG: rd_word = {1'b0, cfg_byte(s)};
            default: rd_word = 9'h000;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // All behaviour is one pass over a copy of the state record.
    always_comb begin
        logic frm;
        logic clk_rise;
        logic clk_fall;
        logic frm_fall;
        logic frm_rise;
        logic din;
        logic [7:0] c;
        logic [8:0] w;
        logic push;
        tstc_wr_t pw;
        tstc_wr_t pe;
        logic done;
        logic [8:0] t;
        logic standalone;
        s_nxt = s_r;
        push = 1'b0;
        pw = '{tgt: TSTC_TGT_NONE, data: 9'h000};
        pe = s_r.fifo[s_r.rp];
        done = 1'b0;
        t = meas_temp;
        c = {s_r.din_s[1], s_r.cmd[7:1]};
        w = {s_r.din_s[1], s_r.rx[8:1]};
        // Levels use the second stage of each synchroniser; edges compare the second and third.
        s_nxt.frm_s = {s_r.frm_s[1:0], frame_pin};
        s_nxt.clk_s = {s_r.clk_s[1:0], clk_or_convert_pin};
        s_nxt.din_s = {s_r.din_s[0], sio_in};
        frm = s_r.frm_s[1];
        din = s_r.din_s[1];
        frm_rise = s_r.frm_s[1] & ~s_r.frm_s[2];
        frm_fall = ~s_r.frm_s[1] & s_r.frm_s[2];
        clk_rise = s_r.clk_s[1] & ~s_r.clk_s[2];
        clk_fall = ~s_r.clk_s[1] & s_r.clk_s[2];

        // Serial port. Frame low forces idle and a released pin.
        if (!frm) begin
            s_nxt.ser = TSTC_IDLE;
            s_nxt.sio_e = 1'b0;
            s_nxt.bits = 4'h0;
        end else begin
            unique case (s_r.ser)
                TSTC_IDLE: begin
                    // A new frame opens with a command byte.
                    if (frm_rise) begin
                        s_nxt.ser = TSTC_CMD;
                        s_nxt.bits = 4'h0;
                    end
                end
                TSTC_CMD: begin
                    if (clk_rise) begin
                        // Bits arrive low first on rising edges.
                        s_nxt.cmd = c;
                        s_nxt.bits = s_r.bits + 4'h1;
                        if (s_r.bits == 4'h7) begin
                            s_nxt.bits = 4'h0;
                            s_nxt.ser = TSTC_DONE;
                            s_nxt.tx = rd_word(s_r, c);
                            unique case (c)
                                `TSTC_CMD_RD_TEMP, `TSTC_CMD_RD_REM,
                                `TSTC_CMD_RD_SLOPE, `TSTC_CMD_RD_UPPER,
                                `TSTC_CMD_RD_LOWER, `TSTC_CMD_RD_CFG: begin
                                    s_nxt.ser = TSTC_RD;
                                end
                                `TSTC_CMD_WR_UPPER: begin
                                    s_nxt.ser = TSTC_WR;
                                    s_nxt.tgt = TSTC_TGT_UPPER;
                                end
                                `TSTC_CMD_WR_LOWER: begin
                                    s_nxt.ser = TSTC_WR;
                                    s_nxt.tgt = TSTC_TGT_LOWER;
                                end
                                `TSTC_CMD_WR_CFG: begin
                                    s_nxt.ser = TSTC_WR;
                                    s_nxt.tgt = TSTC_TGT_CFG;
                                end
                                `TSTC_CMD_START: begin
                                    // Single mode asks one; else runs on.
                                    if (s_r.single) begin
                                        s_nxt.one_req = 1'b1;
                                    end else begin
                                        s_nxt.run = 1'b1;
                                    end
                                end
                                `TSTC_CMD_STOP: begin
                                    s_nxt.run = 1'b0;
                                end
                                default: begin
                                    s_nxt.ser = TSTC_DONE;
                                end
                            endcase
                        end
                    end
                end
                TSTC_RD: begin
                    // Drive after the fall, release while clock high.
                    if (clk_fall) begin
                        s_nxt.sio_e = 1'b1;
                        s_nxt.sio_o = s_r.tx[0];
                        s_nxt.tx = {1'b0, s_r.tx[8:1]};
                    end else if (clk_rise) begin
                        s_nxt.sio_e = 1'b0;
                    end
                end
                TSTC_WR: begin
                    if (clk_rise) begin
                        s_nxt.rx = w;
                        s_nxt.bits = s_r.bits + 4'h1;
                        // Eight bits close a config word, nine a trip.
                        if ((s_r.tgt == TSTC_TGT_CFG &&
                             s_r.bits == 4'(`TSTC_CFG_BITS - 1)) ||
                            s_r.bits == 4'(`TSTC_WORD_BITS - 1)) begin
                            push = 1'b1;
                            pw.tgt = s_r.tgt;
                            pw.data = (s_r.tgt == TSTC_TGT_CFG) ?
                                      {1'b0, w[8:1]} : w;
                            s_nxt.ser = TSTC_DONE;
                        end
                    end
                end
                TSTC_DONE: begin
                    // Extra clocks in a frame are ignored.
                    s_nxt.sio_e = 1'b0;
                end
            endcase
        end

        // Commit buffer: a full buffer refuses the word, so the host
        // must respect the write spacing of the nonvolatile cells.
        if (push && s_r.fill != 2'd2) begin
            s_nxt.fifo[s_r.wp] = pw;
            s_nxt.wp = ~s_r.wp;
        end
        // Draining stalls while a nonvolatile write is under way.
        if (s_r.fill != 2'd0 && !s_r.nv_busy) begin
            s_nxt.rp = ~s_r.rp;
            s_nxt.nv_busy = 1'b1;
            s_nxt.nv_cnt = '0;
            unique case (pe.tgt)
                TSTC_TGT_UPPER: s_nxt.upper = pe.data;
                TSTC_TGT_LOWER: s_nxt.lower = pe.data;
                TSTC_TGT_CFG: begin
                    // Writing zero clears a flag; writing one keeps it.
                    s_nxt.upf = s_r.upf & pe.data[`TSTC_CFG_UPF];
                    s_nxt.lof = s_r.lof & pe.data[`TSTC_CFG_LOF];
                    s_nxt.host_sel = pe.data[`TSTC_CFG_HOST];
                    s_nxt.single = pe.data[`TSTC_CFG_SINGLE];
                end
                TSTC_TGT_NONE: s_nxt.nv_busy = 1'b0;
            endcase
        end
        s_nxt.fill = s_r.fill
                     + 2'((push && s_r.fill != 2'd2) ? 1 : 0)
                     - 2'((s_r.fill != 2'd0 && !s_r.nv_busy) ? 1 : 0);
        // Nonvolatile write timer.
        if (s_r.nv_busy) begin
            s_nxt.nv_cnt = s_r.nv_cnt + 1'b1;
            if (s_r.nv_cnt == NV_LAST) begin
                s_nxt.nv_busy = 1'b0;
            end
        end

        // Stand-alone start from the pin while the frame is low.
        standalone = ~s_r.host_sel & ~frm;
        if (standalone && clk_fall) begin
            s_nxt.one_req = 1'b1;
        end
        if (standalone && !s_r.clk_s[1]) begin
            if (s_r.low_cnt == PULSE_LAST) begin
                s_nxt.pin_cont = 1'b1;
            end else begin
                s_nxt.low_cnt = s_r.low_cnt + 1'b1;
            end
        end else begin
            s_nxt.low_cnt = '0;
            s_nxt.pin_cont = 1'b0;
        end

        // Conversion sequencer.
        if (s_r.conv_busy) begin
            s_nxt.conv_cnt = s_r.conv_cnt + 1'b1;
            if (s_r.conv_cnt == CONV_LAST) begin
                s_nxt.conv_busy = 1'b0;
                done = 1'b1;
            end
        end else if (s_r.one_req || s_r.pin_cont ||
                     (s_r.run && !s_r.single)) begin
            s_nxt.conv_busy = 1'b1;
            s_nxt.conv_cnt = '0;
            s_nxt.one_req = 1'b0;
        end

        // Results and outputs change only at completion, so they hold.
        if (done) begin
            s_nxt.temp = t;
            s_nxt.remain = meas_remain;
            s_nxt.slope = meas_slope;
            s_nxt.hi_o = t_ge(t, s_r.upper);
            s_nxt.lo_o = t_ge(s_r.lower, t);
            if (t_ge(t, s_r.upper)) begin
                s_nxt.com_o = 1'b1;
            end else if (t_ge(s_r.lower, t)) begin
                s_nxt.com_o = 1'b0;
            end
            // A set lands after any clear in the same cycle.
            if (t_ge(t, s_r.upper)) begin
                s_nxt.upf = 1'b1;
            end
            if (t_ge(s_r.lower, t)) begin
                s_nxt.lof = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    // Synchronous reset to power-up values.
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.frm_s <= 3'b000;
            s_r.clk_s <= 3'b111;
            s_r.ser <= TSTC_IDLE;
            s_r.tgt <= TSTC_TGT_NONE;
            s_r.temp <= `TSTC_TEMP_RST;
            s_r.upper <= `TSTC_UPPER_RST;
            s_r.lower <= `TSTC_LOWER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, each straight from the state register
    // ---------------------------------------------------------------
    assign sio_out = s_r.sio_o;
    assign sio_oe = s_r.sio_e;
    assign over_limit_out = s_r.hi_o;
    assign under_limit_out = s_r.lo_o;
    assign hysteresis_out = s_r.com_o;
endmodule

// ===== hw/tstc_map.svh
// Constants of the thermostat three-wire control block.
// Assumes a 100 MHz system clock; the write and pulse counts derive from it.
//
// How it works
// - Over-limit output high while temperature at or above upper.
// - Under-limit output high while temperature at or below lower.
// - Hysteresis output set at upper, cleared at lower.
// - Done bit reads 1 unless conversion running.
// - Upper seen flag sticky until written zero.
// - Lower seen flag sticky until written zero.
// - Busy bit high during nonvolatile write time.
// - Port select zero lets pin start conversions.
// - Single mode converts once; otherwise continuously.
// - Single mode outputs hold last completed result.
// - Short pin pulse one conversion, held low continuous.
// - Pin start overrides single conversion mode.
// - Frame rise starts, frame fall aborts, releases data.
// - Sample on rising edge, drive after falling.
// - Reads release data while serial clock high.
// - Commands and data travel least significant first.
// - Temperature, remainder and slope read commands.
// - Upper and lower trip read commands.
// - Upper and lower trip write commands.
// - Start command begins single or continuous conversion.
// - Stop command ends continuous after current conversion.
// - Config write command takes eight bits.
// - Config read command shifts out eight bits.
// - Temperatures are nine-bit two's complement half degrees.
// - Clocks beyond the word's end yield zeros.
`ifndef TSTC_MAP_SVH
`define TSTC_MAP_SVH
// ---------------------------------------------------------------
// Commands
// ---------------------------------------------------------------
`define TSTC_CMD_RD_TEMP 8'hAA
`define TSTC_CMD_RD_REM 8'hA0
`define TSTC_CMD_RD_SLOPE 8'hA9
`define TSTC_CMD_RD_UPPER 8'hA1
`define TSTC_CMD_RD_LOWER 8'hA2
`define TSTC_CMD_RD_CFG 8'hAC
`define TSTC_CMD_WR_UPPER 8'h01
`define TSTC_CMD_WR_LOWER 8'h02
`define TSTC_CMD_WR_CFG 8'h0C
`define TSTC_CMD_START 8'hEE
`define TSTC_CMD_STOP 8'h22
// ---------------------------------------------------------------
// Config/status fields and reset values
// ---------------------------------------------------------------
`define TSTC_CFG_DONE 7
`define TSTC_CFG_UPF 6
`define TSTC_CFG_LOF 5
`define TSTC_CFG_NVB 4
`define TSTC_CFG_ONE 3
`define TSTC_CFG_ZERO 2
`define TSTC_CFG_HOST 1
`define TSTC_CFG_SINGLE 0
`define TSTC_TEMP_RST 9'h188
`define TSTC_UPPER_RST 9'h01E
`define TSTC_LOWER_RST 9'h014
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TSTC_CLK_HZ 100000000
`define TSTC_NV_WRITE_MS 10
`define TSTC_PULSE_MS 10
`define TSTC_CONV_CYC 2000
`define TSTC_CNT_W 24
`define TSTC_WORD_BITS 9
`define TSTC_CFG_BITS 8
`endif

// ===== hw/tstc_pkg.sv
// Types shared by the thermostat three-wire control block.
// Assumes the constant header is on the include path.
`include "tstc_map.svh"
package tstc_pkg;
    // ---------------------------------------------------------------
    // Serial port states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        TSTC_IDLE, TSTC_CMD, TSTC_RD, TSTC_WR, TSTC_DONE
    } tstc_ser_t;
    // Write target codes carried through the commit buffer.
    typedef enum logic [1:0] {
        TSTC_TGT_NONE, TSTC_TGT_UPPER, TSTC_TGT_LOWER, TSTC_TGT_CFG
    } tstc_tgt_t;
    // One buffered write: target and nine data bits.
    typedef struct packed {
        tstc_tgt_t tgt;
        logic [8:0] data;
    } tstc_wr_t;
endpackage

// ===== dv/tstc_core_sva.sv
// Concurrent checks on the data pin and thermostat outputs of tstc_core.
// Assumes only the core's ports are visible; bound in at the foot.
module tstc_core_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic frame_pin,
    input wire logic clk_or_convert_pin,
    input wire logic sio_out,
    input wire logic sio_oe,
    input wire logic over_limit_out,
    input wire logic under_limit_out,
    input wire logic hysteresis_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // The pins pass a two-stage synchroniser, so five clocks of margin are allowed.
    a_frame_low_release: assert property (!frame_pin [*5] |-> !sio_oe)
        else $error("data pin driven outside a frame");
    a_oe_needs_frame: assert property ($rose(sio_oe) |-> $past(frame_pin, 3))
        else $error("data pin driven too soon after frame rise");
    a_clk_high_release: assert property (clk_or_convert_pin [*5] |-> !sio_oe)
        else $error("data pin driven while serial clock high");
    a_drive_after_fall: assert property ($rose(sio_oe) |-> !$past(clk_or_convert_pin, 2))
        else $error("data pin driven before a clock fall");
    a_bit_steady: assert property (sio_oe && $past(sio_oe) |-> $stable(sio_out))
        else $error("read bit changed while driven");
    a_over_sets_hyst: assert property (over_limit_out |-> hysteresis_out)
        else $error("combined output low while over limit");
    a_hyst_rise_cause: assert property ($rose(hysteresis_out) |-> over_limit_out)
        else $error("combined output rose below upper trip");
    a_hyst_fall_cause: assert property ($fell(hysteresis_out) |-> under_limit_out)
        else $error("combined output fell above lower trip");
    // Main scenarios reached.
    c_read_bit: cover property ($rose(sio_oe));
    c_hyst_set: cover property ($rose(hysteresis_out));
    c_under_set: cover property ($rose(under_limit_out));
endmodule
bind tstc_core tstc_core_sva chk_u (.clock(clock), .rst(rst), .frame_pin(frame_pin),
    .clk_or_convert_pin(clk_or_convert_pin), .sio_out(sio_out), .sio_oe(sio_oe),
    .over_limit_out(over_limit_out), .under_limit_out(under_limit_out),
    .hysteresis_out(hysteresis_out));

// ===== dv/tstc_host_model.sv
// Host controller model for the three-wire port: frame, serial clock, data.
// Assumes the bench calls its tasks; the shared data line is resolved here.
module tstc_host_model (
    output logic frame_pin,
    output logic sclk,
    output logic sio_line,
    input wire logic sio_out,
    input wire logic sio_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv = 1'b0; // High while the host drives the line.
    logic dq = 1'b0; // Host data value.
    logic junk = 1'b0; // Changing filler, so a released line never shows a stale bit.
    initial begin
        frame_pin = 1'b0;
        sclk = 1'b1;
    end
    always #10 junk = ~junk;
    assign sio_line = sio_oe ? sio_out : (drv ? dq : junk);
    // ----------
    // One frame: command, then wn bits written or rn bits read, at 125 ns per bit.
    // ----------
    task automatic xfer(input logic [7:0] cmd, input int wn, input logic [8:0] wd,
                        input int rn, output logic [9:0] rd);
        logic [31:0] tx;
        tx = {15'h0000, wd, cmd};
        rd = 10'h000;
        frame_pin <= 1'b1;
        #125;
        for (int i = 0; i < 8 + wn + rn; i++) begin
            sclk <= 1'b0;
            drv <= (i < 8 + wn);
            dq <= tx[i];
            #62.5;
            if (i >= 8 + wn) begin
                rd[i - 8 - wn] = sio_line;
            end
            sclk <= 1'b1;
            #62.5;
        end
        drv <= 1'b0;
        frame_pin <= 1'b0;
        #100;
    endtask
    // Stand-alone convert pulse on the shared pin, held low for cyc clocks.
    task automatic pulse(input int cyc);
        sclk <= 1'b0;
        #(cyc * 10);
        sclk <= 1'b1;
    endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for tstc_core with a host model on the serial port.
// Assumes the package and constant header compile first.
`include "tstc_map.svh"
module tb
    import tstc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV = 20; // Short conversions keep the run brief.
    localparam int NV = 2000; // Long enough that a busy read lands inside it.
    localparam int PULSE = 200;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sclk, frame_pin, sio_line, sio_out, sio_oe, over, under, hyst;
    logic [8:0] mt = 9'h000;
    logic [8:0] mr = 9'h000;
    logic [8:0] ms = 9'h000;
    logic [8:0] up, lo, t, v;
    logic [9:0] rd;
    logic h, uf, lf, hs, sg; // Expected hysteresis, flags and mode bits.
    int fails = 0;
    int checked = 0;
    int seed = 50818;
    always #5 clock = ~clock;
    tstc_host_model host_u (.frame_pin(frame_pin), .sclk(sclk), .sio_line(sio_line),
        .sio_out(sio_out), .sio_oe(sio_oe));
    tstc_core #(.CONV_CYC(CONV), .NV_CYC(NV), .PULSE_CYC(PULSE)) dut_u (.clock(clock),
        .rst(rst), .frame_pin(frame_pin), .clk_or_convert_pin(sclk), .sio_in(sio_line),
        .sio_out(sio_out), .sio_oe(sio_oe), .meas_temp(mt), .meas_remain(mr),
        .meas_slope(ms), .over_limit_out(over), .under_limit_out(under),
        .hysteresis_out(hyst));
    // ----------
    // Helpers
    // ----------
    function automatic logic ge(input logic [8:0] a, input logic [8:0] b);
        return $signed(a) >= $signed(b);
    endfunction
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rd_cmd(input logic [7:0] c, input int n);
        host_u.xfer(c, 0, 9'h000, n, rd);
    endtask
    task automatic cfg_chk;
        rd_cmd(`TSTC_CMD_RD_CFG, 8);
        check("cfg", rd, {2'h0, 1'b1, uf, lf, 3'h2, hs, sg});
    endtask
    // A write is followed by a busy read, then the full write time is waited out.
    task automatic wr(input logic [7:0] c, input int n, input logic [8:0] d);
        host_u.xfer(c, n, d, 0, rd);
        rd_cmd(`TSTC_CMD_RD_CFG, 8);
        check("busy", {9'h000, rd[4]}, 10'h001);
        repeat (NV) @(posedge clock);
        cfg_chk();
    endtask
    task automatic wcfg(input logic [7:0] d);
        uf = uf & d[6];
        lf = lf & d[5];
        hs = d[1];
        sg = d[0];
        wr(`TSTC_CMD_WR_CFG, 8, {1'b0, d});
    endtask
    task automatic meas(input logic [8:0] nv);
        @(posedge clock);
        mt <= nv;
        mr <= nv ^ 9'h0AA;
        ms <= ~nv;
        @(posedge clock);
    endtask
    // Updates the expected thermostat state when upd is set, then compares outputs.
    task automatic thermo(input logic [8:0] nt, input logic upd);
        if (upd) begin
            t = nt;
            h = ge(t, up) ? 1'b1 : (ge(lo, t) ? 1'b0 : h);
            uf = uf | ge(t, up);
            lf = lf | ge(lo, t);
        end
        check("thermo", {7'h00, over, under, hyst}, {7'h00, ge(t, up), ge(lo, t), h});
    endtask
    // ----------
    // Main sequence
    // ----------
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        repeat (5) @(posedge clock);
        {uf, lf, hs, sg, h} = 5'h00;
        up = `TSTC_UPPER_RST;
        lo = `TSTC_LOWER_RST;
        cfg_chk();
        rd_cmd(`TSTC_CMD_RD_TEMP, 10);
        check("temp", rd, {1'b0, `TSTC_TEMP_RST});
        host_u.xfer(`TSTC_CMD_WR_UPPER, 4, 9'h1F5, 0, rd);
        repeat (NV) @(posedge clock);
        rd_cmd(`TSTC_CMD_RD_UPPER, 9);
        check("upper", rd, {1'b0, up});
        wcfg(8'hF7);
        for (int k = 0; k < 4; k++) begin
            up = 9'($random(seed));
            lo = up - 9'h020;
            wr(`TSTC_CMD_WR_UPPER, 9, up);
            wr(`TSTC_CMD_WR_LOWER, 9, lo);
            rd_cmd(`TSTC_CMD_RD_UPPER, 9);
            check("upper", rd, {1'b0, up});
            rd_cmd(`TSTC_CMD_RD_LOWER, 9);
            check("lower", rd, {1'b0, lo});
            v = (k == 0) ? up : (k == 1) ? lo : (k == 2) ? lo + 9'h001 : 9'($random(seed));
            meas(v);
            rd_cmd(`TSTC_CMD_START, 0);
            repeat (CONV + 10) @(posedge clock);
            thermo(v, 1'b1);
            for (int j = 0; j < 3; j++) begin
                rd_cmd((j == 0) ? `TSTC_CMD_RD_TEMP : (j == 1) ? `TSTC_CMD_RD_REM : `TSTC_CMD_RD_SLOPE, 9);
                check("result", rd, {1'b0, (j == 0) ? v : (j == 1) ? v ^ 9'h0AA : ~v});
            end
            meas(~v);
            repeat (3 * CONV) @(posedge clock);
            thermo(v, 1'b0);
        end
        wcfg(8'h9F); // Clears both flags.
        wcfg(8'h60);
        // Present the last result again so a pass that still converts it changes no output.
        meas(v);
        rd_cmd(`TSTC_CMD_START, 0);
        for (int k = 0; k < 3; k++) begin
            v = 9'($random(seed));
            meas(v);
            repeat (3 * CONV) @(posedge clock);
            thermo(v, 1'b1);
        end
        rd_cmd(`TSTC_CMD_STOP, 0);
        repeat (3 * CONV) @(posedge clock);
        meas(~v);
        repeat (3 * CONV) @(posedge clock);
        thermo(v, 1'b0);
        wcfg(8'h61);
        v = 9'($random(seed));
        meas(v);
        host_u.pulse(30);
        repeat (3 * CONV) @(posedge clock);
        thermo(v, 1'b1);
        meas(~v);
        repeat (3 * CONV) @(posedge clock);
        thermo(v, 1'b0);
        fork
            host_u.pulse(PULSE * 3);
            begin
                repeat (PULSE * 2) @(posedge clock);
                meas(~v);
            end
        join
        repeat (3 * CONV) @(posedge clock);
        thermo(~v, 1'b1);
        wcfg(8'h63);
        meas(v);
        host_u.pulse(30);
        repeat (3 * CONV) @(posedge clock);
        thermo(~v, 1'b0);
        test_done();
    end
    // Watchdog: a hung run counts as a mismatch.
    initial begin
        #900000;
        fails++;
        test_done();
    end
endmodule
